// File: verilog/fecd_cmd_decoder.sv
/*
 Command decoder for a parallel NOR flash: erase, suspend/resume, block
 locking, protection register setup and read configuration load. It hands
 jobs to a simple internal write state machine model (busy counter).
 Assumes bus write strobes arrive on pins and are synchronised here.
*/
`timescale 1ns/1ps
`include "fecd_defines.svh"
module fecd_cmd_decoder #(
    parameter int ADDR_W = 23,
    parameter int BLOCK_W = 4,
    parameter int OP_CYCLES = `FECD_OP_CYCLES
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Host bus pins
    input wire logic i_chip_en_n,
    input wire logic i_write_en_n,
    input wire logic i_out_en_n,
    input wire logic i_address_valid_n,
    input wire logic i_sync_read,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_data,
    // Array read data
    input wire logic [15:0] i_array_data,
    // Read side
    output logic [15:0] o_read_data,
    output fecd_pkg::fecd_read_e o_read_mode,
    // Job and state
    output fecd_pkg::fecd_job_e o_job,
    output logic o_job_start,
    output logic [ADDR_W-1:0] o_job_addr,
    output logic [15:0] o_job_data,
    output logic [7:0] o_status_word,
    output logic [15:0] o_read_config,
    output logic [(1<<BLOCK_W)-1:0] o_locked,
    output logic [(1<<BLOCK_W)-1:0] o_locked_down
);
    import fecd_pkg::*;

    initial
    begin
        if (ADDR_W < 17 || BLOCK_W < 1 || BLOCK_W > ADDR_W - 16 ||
            OP_CYCLES < 2)
            $error("fecd_cmd_decoder: unsupported parameters");
    end

    localparam int BLOCKS = 1 << BLOCK_W;

    // ================================================================
    // Pin synchronisation
    // ================================================================
    logic [3:0] pins_s;
    fecd_sync #(.WIDTH(4)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_async(~{i_chip_en_n, i_write_en_n, i_out_en_n,
                   i_address_valid_n}),
        .o_sync(pins_s)
    );
    // Pins enter inverted so the cleared synchroniser equals the released
    // level; otherwise reset release would look like a strobe edge.
    wire ce_n_s = !pins_s[3];
    wire we_n_s = !pins_s[2];
    wire oe_n_s = !pins_s[1];
    wire adv_n_s = !pins_s[0];

    logic we_n_ff;
    logic ce_n_ff;
    logic oe_n_ff;
    logic adv_n_ff;
    // A write is taken on the rising edge of the write strobe while selected;
    // address and data are assumed held by the host across that edge.
    wire wr_pulse = !we_n_ff && we_n_s && !ce_n_s;
    wire [7:0] cmd = i_data[7:0];

    // ================================================================
    // Decoder state
    // ================================================================
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ERASE_SETUP = 5'b00010,
        ST_CFG_SETUP = 5'b00100,
        ST_PROT_SETUP = 5'b01000,
        ST_PROG_SETUP = 5'b10000
    } fecd_pend_e;

    fecd_pend_e pend_ff;
    fecd_pend_e nxt_pend;
    fecd_read_e rmode_ff;
    fecd_read_e nxt_rmode;
    fecd_job_e job_ff;
    fecd_job_e nxt_job;
    logic busy_ff;
    logic nxt_busy;
    logic susp_ff;
    logic nxt_susp;
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic prog_err_ff;
    logic erase_err_ff;
    logic nxt_prog_err;
    logic nxt_erase_err;
    logic [15:0] rcr_ff;
    logic [15:0] nxt_rcr;
    logic start_ff;
    logic nxt_start;
    logic [ADDR_W-1:0] jaddr_ff;
    logic [15:0] jdata_ff;
    logic [15:0] rdata_ff;
    logic lock_req;
    logic unlock_req;
    logic lockdown_req;

    wire active = busy_ff && !susp_ff;
    wire job_done = active && (cnt_ff == 32'h1);

    // ================================================================
    // Command decode
    // ================================================================
    always_comb
    begin
        nxt_pend = pend_ff;
        nxt_rmode = rmode_ff;
        nxt_job = job_ff;
        nxt_busy = busy_ff;
        nxt_susp = susp_ff;
        nxt_cnt = active ? cnt_ff - 32'h1 : cnt_ff;
        nxt_prog_err = prog_err_ff;
        nxt_erase_err = erase_err_ff;
        nxt_rcr = rcr_ff;
        nxt_start = 1'b0;
        lock_req = 1'b0;
        unlock_req = 1'b0;
        lockdown_req = 1'b0;
        if (job_done)
        begin
            nxt_busy = 1'b0;
            nxt_job = FECD_JOB_NONE;
        end
        if (wr_pulse)
        begin
            if (active)
            begin
                // Only status read and suspend reach a running job
                if (cmd == `FECD_CMD_READ_STATUS)
                    nxt_rmode = FECD_RD_STATUS;
                else if (cmd == `FECD_CMD_SUSPEND)
                    nxt_susp = 1'b1;
            end
            else if (pend_ff != ST_IDLE)
            begin
                nxt_pend = ST_IDLE;
                unique case (pend_ff)
                    ST_ERASE_SETUP:
                    begin
                        if (cmd == `FECD_CMD_CONFIRM)
                        begin
                            nxt_job = FECD_JOB_ERASE;
                            nxt_busy = 1'b1;
                            nxt_start = 1'b1;
                            nxt_cnt = OP_CYCLES;
                        end
                        else
                        begin
                            nxt_prog_err = 1'b1;
                            nxt_erase_err = 1'b1;
                        end
                        nxt_rmode = FECD_RD_STATUS;
                    end
                    ST_CFG_SETUP:
                    begin
                        if (cmd == `FECD_CMD_RCR_LOAD)
                        begin
                            nxt_rcr = i_addr[15:0];
                            nxt_rmode = FECD_RD_ARRAY;
                        end
                        else if (cmd == `FECD_CMD_LOCK)
                            lock_req = 1'b1;
                        else if (cmd == `FECD_CMD_LOCKDOWN)
                            lockdown_req = 1'b1;
                        else if (cmd == `FECD_CMD_CONFIRM)
                            unlock_req = 1'b1;
                        else
                        begin
                            nxt_prog_err = 1'b1;
                            nxt_erase_err = 1'b1;
                        end
                    end
                    ST_PROT_SETUP, ST_PROG_SETUP:
                    begin
                        nxt_job = (pend_ff == ST_PROT_SETUP) ?
                            FECD_JOB_PROT : FECD_JOB_PROGRAM;
                        nxt_busy = 1'b1;
                        nxt_start = 1'b1;
                        nxt_cnt = OP_CYCLES;
                        nxt_rmode = FECD_RD_STATUS;
                    end
                    default:
                        nxt_pend = ST_IDLE;
                endcase
            end
            else if (susp_ff && cmd == `FECD_CMD_CONFIRM)
                nxt_susp = 1'b0;
            else
            begin
                unique case (cmd)
                    `FECD_CMD_ERASE_SETUP:
                        if (!susp_ff)
                            nxt_pend = ST_ERASE_SETUP;
                    `FECD_CMD_LOCK_SETUP:
                        nxt_pend = ST_CFG_SETUP;
                    `FECD_CMD_PROT_SETUP:
                        if (!susp_ff)
                            nxt_pend = ST_PROT_SETUP;
                    `FECD_CMD_PROGRAM, `FECD_CMD_PROGRAM_ALT:
                        if (!busy_ff)
                            nxt_pend = ST_PROG_SETUP;
                    `FECD_CMD_READ_STATUS:
                        nxt_rmode = FECD_RD_STATUS;
                    `FECD_CMD_READ_ARRAY:
                        nxt_rmode = FECD_RD_ARRAY;
                    `FECD_CMD_CLEAR_STATUS:
                    begin
                        nxt_prog_err = 1'b0;
                        nxt_erase_err = 1'b0;
                    end
                    default:
                        nxt_rmode = rmode_ff;
                endcase
            end
        end
    end

    // ================================================================
    // Registers
    // ================================================================
    // Reset pin ends a suspend or a running job at once; resume ends a suspend and counter expiry ends a running job
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pend_ff <= ST_IDLE;
            rmode_ff <= FECD_RD_ARRAY;
            job_ff <= FECD_JOB_NONE;
            busy_ff <= 1'b0;
            susp_ff <= 1'b0;
            cnt_ff <= 32'h0;
            prog_err_ff <= 1'b0;
            erase_err_ff <= 1'b0;
            rcr_ff <= `FECD_RCR_RESET;
            start_ff <= 1'b0;
        end
        else
        begin
            pend_ff <= nxt_pend;
            rmode_ff <= nxt_rmode;
            job_ff <= nxt_job;
            busy_ff <= nxt_busy;
            susp_ff <= nxt_susp;
            cnt_ff <= nxt_cnt;
            prog_err_ff <= nxt_prog_err;
            erase_err_ff <= nxt_erase_err;
            rcr_ff <= nxt_rcr;
            start_ff <= nxt_start;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            jaddr_ff <= '0;
            jdata_ff <= 16'h0;
            we_n_ff <= 1'b1;
            ce_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            adv_n_ff <= 1'b1;
        end
        else
        begin
            if (nxt_start)
            begin
                jaddr_ff <= i_addr;
                jdata_ff <= i_data;
            end
            we_n_ff <= we_n_s;
            ce_n_ff <= ce_n_s;
            oe_n_ff <= oe_n_s;
            adv_n_ff <= adv_n_s;
        end
    end

    // ================================================================
    // Status word and read output
    // ================================================================
    logic [7:0] status_now;
    assign status_now[`FECD_SR_READY] = !active;
    assign status_now[`FECD_SR_ERASE_SUSP] = susp_ff &&
        (job_ff == FECD_JOB_ERASE);
    assign status_now[`FECD_SR_ERASE_ERR] = erase_err_ff;
    assign status_now[`FECD_SR_PROG_ERR] = prog_err_ff;
    assign status_now[3] = 1'b0;
    assign status_now[`FECD_SR_PROG_SUSP] = susp_ff &&
        (job_ff != FECD_JOB_ERASE);
    assign status_now[1:0] = 2'h0;

    // Status is sampled only on a new access, so a host polling with a
    // steady strobe sees a frozen value.
    wire async_touch = (ce_n_ff && !ce_n_s) || (oe_n_ff && !oe_n_s);
    wire sync_touch = (ce_n_ff && !ce_n_s) || (adv_n_ff && !adv_n_s);
    wire refresh = i_sync_read ? sync_touch : async_touch;

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            rdata_ff <= 16'h0;
        else if (rmode_ff == FECD_RD_ARRAY)
            rdata_ff <= i_array_data;
        else if (refresh)
            rdata_ff <= {8'h00, status_now};
    end

    // ================================================================
    // Lock table
    // ================================================================
    fecd_lock_table #(.BLOCKS(BLOCKS)) u_locks (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_block(i_addr[ADDR_W-1 -: BLOCK_W]),
        .i_lock(lock_req),
        .i_unlock(unlock_req),
        .i_lockdown(lockdown_req),
        .o_locked(o_locked),
        .o_locked_down(o_locked_down)
    );

    assign o_read_data = rdata_ff;
    assign o_read_mode = rmode_ff;
    assign o_job = job_ff;
    assign o_job_start = start_ff;
    assign o_job_addr = jaddr_ff;
    assign o_job_data = jdata_ff;
    assign o_status_word = status_now;
    assign o_read_config = rcr_ff;

    // ================================================================
    // Assertions
    // ================================================================
    sequence s_erase_armed;
        wr_pulse && active == 1'b0 && pend_ff == ST_IDLE && !susp_ff &&
        cmd == `FECD_CMD_ERASE_SETUP;
    endsequence
    sequence s_bad_second;
        wr_pulse && pend_ff == ST_ERASE_SETUP && cmd != `FECD_CMD_CONFIRM;
    endsequence

    a_erase_arm: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        s_erase_armed |=> pend_ff == ST_ERASE_SETUP)
        else $error("erase setup not armed");
    a_erase_bad: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        s_bad_second |=> prog_err_ff && erase_err_ff &&
        rmode_ff == FECD_RD_STATUS)
        else $error("erase sequence error not flagged");
    a_erase_go: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        wr_pulse && pend_ff == ST_ERASE_SETUP && cmd == `FECD_CMD_CONFIRM
        |=> o_job_start && job_ff == FECD_JOB_ERASE && busy_ff)
        else $error("erase not started");
    a_busy_ignore: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n)
        wr_pulse && active && cmd == `FECD_CMD_ERASE_SETUP
        |=> pend_ff == $past(pend_ff))
        else $error("command taken while busy");
    a_suspend: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        wr_pulse && active && cmd == `FECD_CMD_SUSPEND
        |=> susp_ff && status_now[`FECD_SR_READY])
        else $error("suspend failed");
    a_susp_hold: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n)
        susp_ff && !(wr_pulse && cmd == `FECD_CMD_CONFIRM) |=> susp_ff)
        else $error("suspend left without resume");
    a_resume: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        wr_pulse && susp_ff && pend_ff == ST_IDLE &&
        cmd == `FECD_CMD_CONFIRM |=> !susp_ff)
        else $error("resume failed");
    a_cfg_load: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        wr_pulse && !active && pend_ff == ST_CFG_SETUP &&
        cmd == `FECD_CMD_RCR_LOAD
        |=> rcr_ff == $past(i_addr[15:0]) &&
        rmode_ff == FECD_RD_ARRAY)
        else $error("read config not loaded");
    a_pend_clear: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n)
        wr_pulse && !active && pend_ff != ST_IDLE |=> pend_ff == ST_IDLE)
        else $error("pending setup not cleared");
endmodule : fecd_cmd_decoder

// File: verilog/fecd_defines.svh
/*
 Command codes, status bit positions, read config reset value and timing counts for the
 flash command decoder. Assumes inclusion by bare name from design files.
*/
`ifndef FECD_DEFINES_SVH
`define FECD_DEFINES_SVH
`define FECD_CMD_ERASE_SETUP 8'h20
`define FECD_CMD_CONFIRM 8'hD0
`define FECD_CMD_SUSPEND 8'hB0
`define FECD_CMD_LOCK_SETUP 8'h60
`define FECD_CMD_LOCK 8'h01
`define FECD_CMD_LOCKDOWN 8'h2F
`define FECD_CMD_RCR_LOAD 8'h03
`define FECD_CMD_PROT_SETUP 8'hC0
`define FECD_CMD_READ_STATUS 8'h70
`define FECD_CMD_CLEAR_STATUS 8'h50
`define FECD_CMD_READ_ARRAY 8'hFF
`define FECD_CMD_PROGRAM 8'h40
`define FECD_CMD_PROGRAM_ALT 8'h10
`define FECD_SR_PROG_SUSP 2
`define FECD_SR_PROG_ERR 4
`define FECD_SR_ERASE_ERR 5
`define FECD_SR_ERASE_SUSP 6
`define FECD_SR_READY 7
`define FECD_RCR_RESET 16'hBFCF
`define FECD_OP_TIME_NS 1000
`define FECD_CLK_NS 5
`define FECD_OP_CYCLES ((`FECD_OP_TIME_NS + `FECD_CLK_NS - 1) / `FECD_CLK_NS)
`endif

// File: verilog/fecd_pkg.sv
/*
 Types shared by the flash command decoder and its helpers.
 Assumes fecd_defines.svh supplies the numeric constants.
*/
package fecd_pkg;
    typedef enum logic [1:0] {
        FECD_RD_ARRAY = 2'h0,
        FECD_RD_STATUS = 2'h1
    } fecd_read_e;
    typedef enum logic [3:0] {
        FECD_JOB_NONE = 4'h0,
        FECD_JOB_ERASE = 4'h1,
        FECD_JOB_PROGRAM = 4'h2,
        FECD_JOB_PROT = 4'h3
    } fecd_job_e;
endpackage : fecd_pkg

// File: verilog/fecd_sync.sv
/*
 Three-stage synchroniser with agreement filter for pin inputs.
 Assumes the input is asynchronous to i_sys_clk.
*/
`timescale 1ns/1ps
module fecd_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] out_ff;
    logic [WIDTH-1:0] nxt_out;
    // Change counts only once stages two and three agree
    assign nxt_out = (s2_ff & s3_ff) | (out_ff & (s2_ff | s3_ff));
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            out_ff <= '0;
        end
        else
        begin
            s1_ff <= i_async;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end
    assign o_sync = out_ff;
endmodule : fecd_sync

// File: verilog/fecd_lock_table.sv
/*
 Per-block lock and lock-down bits. Assumes one update strobe per cycle.
 Lock-down is cleared only by reset, as in the real array.
*/
`timescale 1ns/1ps
module fecd_lock_table #(
    parameter int BLOCKS = 16
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Update
    input wire logic [$clog2(BLOCKS)-1:0] i_block,
    input wire logic i_lock,
    input wire logic i_unlock,
    input wire logic i_lockdown,
    // State
    output logic [BLOCKS-1:0] o_locked,
    output logic [BLOCKS-1:0] o_locked_down
);
    localparam int IDX_W = $clog2(BLOCKS);

    initial
    begin
        if (BLOCKS < 2)
            $error("fecd_lock_table: BLOCKS must be two or more");
    end

    genvar g;
    generate
        for (g = 0; g < BLOCKS; g++)
        begin : g_blk
            logic lk_ff;
            logic ld_ff;
            logic hit;
            assign hit = (i_block == IDX_W'(g));
            always_ff @(posedge i_sys_clk or negedge i_reset_n)
            begin
                if (!i_reset_n)
                begin
                    lk_ff <= 1'b1;
                    ld_ff <= 1'b0;
                end
                else if (hit)
                begin
                    if (i_lock || i_lockdown)
                        lk_ff <= 1'b1;
                    else if (i_unlock && !ld_ff)
                        lk_ff <= 1'b0;
                    if (i_lockdown)
                        ld_ff <= 1'b1;
                end
            end
            assign o_locked[g] = lk_ff;
            assign o_locked_down[g] = ld_ff;
        end
    endgenerate
endmodule : fecd_lock_table

// File: verification/fecd_host_model.sv
/*
 Host controller model: write and read cycles on the flash bus pins.
 Assumes a 5 ns clock; callers enter its tasks at a falling edge.
*/
`timescale 1ns/1ps
module fecd_host_model (
    // Clock
    input wire logic i_sys_clk,
    // Bus pins towards the decoder
    output logic o_chip_en_n,
    output logic o_write_en_n,
    output logic o_out_en_n,
    output logic [22:0] o_addr,
    output logic [15:0] o_data,
    output logic [15:0] o_array_data,
    // Read data from the decoder
    input wire logic [15:0] i_read_data
);
    initial
    begin
        o_chip_en_n = 1'b1;
        o_write_en_n = 1'b1;
        o_out_en_n = 1'b1;
        o_addr = 23'h000000;
        o_data = 16'h0000;
    end
    // Array contents follow the address so array reads can be checked
    assign o_array_data = o_addr[15:0] ^ 16'hA5C3;
    // ==========================================================
    // Bus cycles
    // Eight clocks per phase: the pins cross a synchroniser first
    task automatic hold_phase();
        repeat (8) @(negedge i_sys_clk);
    endtask : hold_phase
    task automatic write_cycle(input logic [22:0] a, input logic [15:0] d);
        o_addr = a;
        o_data = d;
        o_chip_en_n = 1'b0;
        o_write_en_n = 1'b0;
        hold_phase();
        o_write_en_n = 1'b1;
        hold_phase();
        o_chip_en_n = 1'b1;
        // Released data bus must not keep showing the old value
        o_data = ~d;
        hold_phase();
    endtask : write_cycle
    task automatic read_cycle(output logic [15:0] d);
        o_chip_en_n = 1'b0;
        o_out_en_n = 1'b0;
        hold_phase();
        d = i_read_data;
        o_out_en_n = 1'b1;
        o_chip_en_n = 1'b1;
        hold_phase();
    endtask : read_cycle
endmodule : fecd_host_model

// File: verification/flash_erase_lock_cmd_decoder_tb_top.sv
/*
 Testbench for the flash command decoder, driven through the host model.
 Assumes the long erase time is shortened through OP_CYCLES.
*/
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        compares++; \
        if ((g) !== (e)) \
        begin \
            num_errors++; \
            $display("mismatch %0t got %h exp %h", $time, g, e); \
        end \
    end
module flash_erase_lock_cmd_decoder_tb_top;
    import fecd_pkg::*;
    localparam int OPC = 120;
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic ce_n, we_n, oe_n;
    logic [22:0] addr, job_addr;
    logic [15:0] data, array_data, read_data, job_data, read_config, rd;
    logic [7:0] status_word;
    logic [15:0] locked, locked_down;
    logic job_start;
    logic sync_rd = 1'b0;
    fecd_read_e read_mode;
    fecd_job_e job;
    int num_errors = 0;
    int compares = 0;
    int starts = 0;
    always #2.5 i_sys_clk = ~i_sys_clk;
    always @(negedge i_sys_clk)
    begin
        if (job_start === 1'b1)
            starts++;
    end
    fecd_host_model host (.i_sys_clk(i_sys_clk), .o_chip_en_n(ce_n),
        .o_write_en_n(we_n), .o_out_en_n(oe_n), .o_addr(addr),
        .o_data(data), .o_array_data(array_data), .i_read_data(read_data));
    fecd_cmd_decoder #(.ADDR_W(23), .BLOCK_W(4), .OP_CYCLES(OPC)) dut (
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_chip_en_n(ce_n),
        .i_write_en_n(we_n), .i_out_en_n(oe_n), .i_address_valid_n(1'b0),
        .i_sync_read(sync_rd), .i_addr(addr), .i_data(data),
        .i_array_data(array_data), .o_read_data(read_data),
        .o_read_mode(read_mode), .o_job(job), .o_job_start(job_start),
        .o_job_addr(job_addr), .o_job_data(job_data),
        .o_status_word(status_word), .o_read_config(read_config),
        .o_locked(locked), .o_locked_down(locked_down));
    // ==========================================================
    // Helpers
    task automatic give_verdict();
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic cmd(input logic [7:0] code, input logic [22:0] a);
        host.write_cycle(a, {8'h00, code});
    endtask : cmd
    task automatic wait_ready();
        int n;
        n = 0;
        while (status_word[7] !== 1'b1 && n < 400)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        if (n >= 400)
        begin
            num_errors++;
            $display("mismatch %0t ready timeout", $time);
            give_verdict();
        end
    endtask : wait_ready
    task automatic lock_op(input logic [7:0] code, input logic [3:0] b);
        cmd(8'h60, {b, 19'h00000});
        cmd(code, {b, 19'h00000});
    endtask : lock_op
    // ==========================================================
    // Scenarios
    initial
    begin
        repeat (2) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_reset_n = 1'b1;
        `CHK(status_word, 8'h80)
        `CHK(read_config, 16'hBFCF)
        `CHK(locked, 16'hFFFF)
        cmd(8'h20, 23'h101234);
        cmd(8'hD0, 23'h101234);
        `CHK(job, FECD_JOB_ERASE)
        `CHK(job_addr, 23'h101234)
        `CHK(read_mode, FECD_RD_STATUS)
        `CHK(status_word[7], 1'b0)
        cmd(8'hFF, 23'h000000);
        `CHK(read_mode, FECD_RD_STATUS)
        cmd(8'hB0, 23'h3F0000);
        `CHK(status_word, 8'hC0)
        repeat (100) @(negedge i_sys_clk);
        `CHK(status_word, 8'hC0)
        host.read_cycle(rd);
        `CHK(rd, 16'h00C0)
        cmd(8'hD0, 23'h000007);
        `CHK(status_word[7:6], 2'b00)
        wait_ready();
        `CHK(job, FECD_JOB_NONE)
        cmd(8'h20, 23'h000000);
        cmd(8'h70, 23'h000000);
        `CHK(status_word, 8'hB0)
        `CHK(read_data, 16'h0080)
        sync_rd = 1'b1;
        host.read_cycle(rd);
        `CHK(rd, 16'h00B0)
        sync_rd = 1'b0;
        cmd(8'h50, 23'h000000);
        `CHK(status_word, 8'h80)
        cmd(8'hFF, 23'h004321);
        `CHK(read_mode, FECD_RD_ARRAY)
        host.read_cycle(rd);
        `CHK(rd, 16'h4321 ^ 16'hA5C3)
        lock_op(8'hD0, 4'h3);
        `CHK(locked[3], 1'b0)
        lock_op(8'h2F, 4'h3);
        `CHK({locked[3], locked_down[3]}, 2'b11)
        lock_op(8'hD0, 4'h3);
        `CHK(locked[3], 1'b1)
        lock_op(8'hD0, 4'h5);
        `CHK(locked[5], 1'b0)
        lock_op(8'h01, 4'h5);
        `CHK(locked[5], 1'b1)
        lock_op(8'h55, 4'h0);
        `CHK(status_word, 8'hB0)
        cmd(8'hD0, 23'h000000);
        `CHK(job, FECD_JOB_NONE)
        cmd(8'h50, 23'h000000);
        cmd(8'h70, 23'h000000);
        `CHK(read_mode, FECD_RD_STATUS)
        cmd(8'h60, 23'h001234);
        cmd(8'h03, 23'h0A5678);
        `CHK(read_config, 16'h5678)
        `CHK(read_mode, FECD_RD_ARRAY)
        cmd(8'hC0, 23'h000080);
        host.write_cycle(23'h000081, 16'hABCD);
        `CHK(job, FECD_JOB_PROT)
        `CHK(job_data, 16'hABCD)
        wait_ready();
        cmd(8'hFF, 23'h000100);
        cmd(8'h40, 23'h000100);
        host.write_cycle(23'h000100, 16'h1234);
        `CHK(job, FECD_JOB_PROGRAM)
        `CHK(read_mode, FECD_RD_STATUS)
        cmd(8'hB0, 23'h000000);
        `CHK(status_word, 8'h84)
        cmd(8'hD0, 23'h000000);
        `CHK(status_word[7], 1'b0)
        wait_ready();
        cmd(8'h20, 23'h080000);
        cmd(8'hD0, 23'h080000);
        `CHK(starts, 4)
        i_reset_n = 1'b0;
        @(negedge i_sys_clk);
        `CHK(job, FECD_JOB_NONE)
        `CHK(status_word, 8'h80)
        `CHK(locked_down, 16'h0000)
        i_reset_n = 1'b1;
        repeat (4) @(negedge i_sys_clk);
        `CHK(read_config, 16'hBFCF)
        `CHK(read_mode, FECD_RD_ARRAY)
        give_verdict();
    end
endmodule : flash_erase_lock_cmd_decoder_tb_top
